// *** src/serial_latched_driver.sv ***
// Purpose: Serial-in, latched, eight-way open-collector driver logic.
// Assumes: All pin inputs synchronous to i_clk; the shift clock pin is
//          sampled at 50 MHz and each of its levels lasts a cycle or more.
// Notes:   Latch and driver updates lag the causing pin by one i_clk cycle
//          each, because every output comes from a flip-flop.

`timescale 1ns/1ns

// Summary of operation
// - A rising shift clock edge loads the serial data input into stage one.
// - Each rising shift clock edge moves every stage one place toward the tail.
// - There are eight stages and eight latches, and the tail feeds the serial output.
// - A high strobe makes the latches follow the stages, a low strobe holds them.
// - A high output enable turns all drivers off and leaves stages and latches alone.
// - A low output enable lets each driver show its latch.
module serial_latched_driver
  import driver_pkg::*;
(
  // Clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  // Serial input pins
  input  wire logic       i_shift_clk,
  input  wire logic       i_sdi,
  // Latch and output control pins
  input  wire logic       i_strobe,
  input  wire logic       i_out_en_n,
  // Cascade output
  output logic            o_sdo,
  // Open-collector drivers, enable low while sinking
  output logic [7:0]      o_drv_out,
  output logic [7:0]      o_drv_oe_n
);

  // ************************************************************
  // Shift chain
  // ************************************************************
  shift_link_if link ();

  // The chain relies on i_sdi being settled at the sampled edge
  shift_stage u_shift_stage (
    .i_clk       (i_clk),
    .i_rst_n     (i_rst_n),
    .i_shift_clk (i_shift_clk),
    .i_sdi       (i_sdi),
    .link        (link)
  );

  // Tail stage is a flip-flop inside the shift stage
  assign o_sdo = link.stages[LAST_STAGE];

  // ************************************************************
  // Latches
  // ************************************************************
  logic [7:0] latch_reg;
  logic [7:0] latch_next;

  // A flop-based latch: transparency costs one cycle of lag, but
  // keeps the block free of level-sensitive storage.
  always_comb begin
    latch_next = latch_reg;
    if (i_strobe) begin
      latch_next = link.stages;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      latch_reg <= LATCH_RESET;
    end else begin
      latch_reg <= latch_next;
    end
  end

  // ************************************************************
  // Output drivers
  // ************************************************************
  logic [7:0] drv_oe_n_next;

  // A set latch bit turns its driver on (sinking); the enable only
  // gates the drivers and never touches latch or chain contents.
  always_comb begin
    if (i_out_en_n) begin
      drv_oe_n_next = DRV_OE_N_OFF;
    end else begin
      drv_oe_n_next = ~latch_reg;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_drv_oe_n <= DRV_OE_N_OFF;
    end else begin
      o_drv_oe_n <= drv_oe_n_next;
    end
  end

  // Open-collector: the pin level when enabled is always low
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_drv_out <= DRV_OUT_LEVEL;
    end else begin
      o_drv_out <= DRV_OUT_LEVEL;
    end
  end

  // ************************************************************
  // Depth probe
  // ************************************************************
  // Follows one captured bit down the chain, so a chain one stage short
  // or long trips a_chain_depth; it feeds no output.
  logic [3:0] probe_count_reg;
  logic       probe_bit_reg;

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      probe_count_reg <= 4'h0;
      probe_bit_reg   <= 1'b0;
    end else if (link.shift_edge) begin
      if (probe_count_reg == 4'h0 || probe_count_reg == 4'(STAGE_COUNT)) begin
        probe_count_reg <= 4'h1;
        probe_bit_reg   <= i_sdi;
      end else begin
        probe_count_reg <= probe_count_reg + 4'h1;
      end
    end
  end

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge i_clk);
  endclocking

  default disable iff (!i_rst_n);

  sequence s_load_shown;
    (i_strobe && !i_out_en_n) ##1 !i_out_en_n;
  endsequence

  sequence s_quiet_disabled;
    (i_out_en_n && !link.shift_edge && !i_strobe) [*2];
  endsequence

  sequence s_two_shifts;
    link.shift_edge ##1 !link.shift_edge [*2] ##1 link.shift_edge;
  endsequence

  sequence s_held_shown;
    (!i_strobe && !i_out_en_n) [*2];
  endsequence

  a_first_stage_capture: assert property (
    link.shift_edge |=> link.stages[0] == $past(i_sdi)
  ) else $error("stage one did not take serial input");

  a_stage_advance: assert property (
    link.shift_edge |=> link.stages[7:1] == $past(link.stages[6:0])
  ) else $error("stages did not advance on shift edge");

  a_tail_two_steps: assert property (
    s_two_shifts |=> link.stages[7:2] == $past(link.stages[5:0], 4)
  ) else $error("two shifts did not move data two places");

  a_chain_depth: assert property (
    probe_count_reg == 4'(STAGE_COUNT) |-> o_sdo == probe_bit_reg
  ) else $error("captured bit did not reach the tail after eight shifts");

  a_sdi_noise_hold: assert property (
    !link.shift_edge && $changed(i_sdi) |=> $stable(link.stages[0])
  ) else $error("stage one moved with data noise and no shift edge");

  a_serial_tail_out: assert property (
    link.shift_edge |=> o_sdo == $past(link.stages[6])
  ) else $error("serial output is not the old seventh stage");

  a_chain_hold: assert property (
    !link.shift_edge |=> $stable(link.stages) && $stable(o_sdo)
  ) else $error("chain changed without a shift edge");

  a_latch_follow: assert property (
    i_strobe |=> latch_reg == $past(link.stages)
  ) else $error("latch did not follow stages under strobe");

  a_latch_hold: assert property (
    !i_strobe |=> $stable(latch_reg)
  ) else $error("latch changed with strobe low");

  a_pins_held: assert property (
    s_held_shown |=> $stable(o_drv_oe_n)
  ) else $error("drivers changed while strobe low and enabled");

  a_drivers_off: assert property (
    i_out_en_n |=> o_drv_oe_n == DRV_OE_N_OFF
  ) else $error("driver on while output enable high");

  a_disable_keeps: assert property (
    s_quiet_disabled |-> $stable(latch_reg) && $stable(link.stages)
  ) else $error("disable disturbed latch or chain");

  a_drivers_track: assert property (
    !i_out_en_n |=> o_drv_oe_n == ~$past(latch_reg)
  ) else $error("driver does not show its latch");

  a_load_to_pins: assert property (
    s_load_shown |=> o_drv_oe_n == ~$past(link.stages, 2)
  ) else $error("strobed pattern not on drivers two cycles later");

  a_pin_level_low: assert property (
    o_drv_out == DRV_OUT_LEVEL
  ) else $error("open-collector pin driven high");

  a_reset_clears: assert property (
    disable iff (1'b0)
    !i_rst_n |=> link.stages == STAGE_RESET && latch_reg == LATCH_RESET &&
                 o_drv_oe_n == DRV_OE_N_OFF && !o_sdo
  ) else $error("reset did not clear chain, latches and drivers");

endmodule : serial_latched_driver

// *** src/driver_pkg.sv ***
// Purpose: Shared constants for the serial-in latched driver block.
// Assumes: One system clock; all pin inputs already synchronous to it.
// Notes:   Stage count and the chain, latch and driver reset values live here.

package driver_pkg;

  // ************************************************************
  // Geometry
  // ************************************************************
  localparam int          STAGE_COUNT   = 8;
  localparam int          LAST_STAGE    = STAGE_COUNT - 1;

  // ************************************************************
  // Reset values
  // ************************************************************
  localparam logic [7:0]  STAGE_RESET   = 8'h00;
  localparam logic [7:0]  LATCH_RESET   = 8'h00;
  // Every driver released (not sinking) after reset
  localparam logic [7:0]  DRV_OE_N_OFF  = 8'hff;
  // Open-collector pins never drive a high level
  localparam logic [7:0]  DRV_OUT_LEVEL = 8'h00;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int          CLK_PERIOD_NS = 20;
  // Least gap from last shift clock activation to strobe rising
  localparam int          STROBE_GAP_NS = 300;
  localparam int          STROBE_GAP_CYC =
    (STROBE_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage : driver_pkg

// *** src/shift_link_if.sv ***
// Purpose: Carries the shift chain state from the shift stage to the top.
// Assumes: Single clock domain.
// Notes:   stages[7] is the serial tail that feeds the cascade output.

`timescale 1ns/1ns

interface shift_link_if;
  logic [7:0] stages;
  logic       shift_edge;

  modport source (
    output stages,
    output shift_edge
  );

  modport sink (
    input  stages,
    input  shift_edge
  );
endinterface : shift_link_if

// *** src/shift_stage.sv ***
// Purpose: Eight-stage serial-in shift register stepped by the shift clock pin.
// Assumes: i_shift_clk is synchronous to i_clk and stays high or low for
//          at least one i_clk period.
// Notes:   The pin is sampled, not used as a clock, so the block keeps one
//          clock domain.

`timescale 1ns/1ns

module shift_stage
  import driver_pkg::*;
(
  // Clock and reset
  input  wire logic   i_clk,
  input  wire logic   i_rst_n,
  // Serial pins
  input  wire logic   i_shift_clk,
  input  wire logic   i_sdi,
  // Chain state
  shift_link_if.source link
);

  logic       clk_prev_reg;
  logic [7:0] stages_reg;
  logic [7:0] stages_next;

  // ************************************************************
  // Shift clock edge
  // ************************************************************
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      clk_prev_reg <= 1'b0;
    end else begin
      clk_prev_reg <= i_shift_clk;
    end
  end

  assign link.shift_edge = i_shift_clk & ~clk_prev_reg;

  // ************************************************************
  // Shift chain
  // ************************************************************
  always_comb begin
    stages_next = stages_reg;
    if (link.shift_edge) begin
      stages_next = {stages_reg[LAST_STAGE-1:0], i_sdi};
    end
  end

  // Without an edge the chain holds, whatever i_sdi does
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      stages_reg <= STAGE_RESET;
    end else begin
      stages_reg <= stages_next;
    end
  end

  assign link.stages = stages_reg;

endmodule : shift_stage

// *** testbench/host_model.sv ***
// Purpose: Behavioural host controller for the latched driver block.
// Assumes: Pins change just after rising i_clk edges.
// Notes:   Shift clock rests low between bytes.

`timescale 1ns/1ns

module host_model
  import driver_pkg::*;
(
  // Clock
  input  wire logic i_clk,
  // Pins to the device
  output logic      o_shift_clk,
  output logic      o_sdi,
  output logic      o_strobe,
  output logic      o_out_en_n
);
  initial begin
    o_shift_clk = 1'b0;
    o_sdi       = 1'b0;
    o_strobe    = 1'b0;
    o_out_en_n  = 1'b1;
  end

  // ************************************************************
  // Pin sequences
  // ************************************************************
  // Top bit first so that it ends in the tail stage
  task automatic shift_byte(input logic [7:0] data, input int hi_cyc);
    for (int i = 7; i >= 0; i--) begin
      @(posedge i_clk) o_sdi <= data[i];
      @(posedge i_clk) o_shift_clk <= 1'b1;
      repeat (hi_cyc) @(posedge i_clk);
      o_shift_clk <= 1'b0;
    end
  endtask : shift_byte

  // Data line noise with the shift clock resting low
  task automatic wiggle_sdi(input int n);
    repeat (n) @(posedge i_clk) o_sdi <= ~o_sdi;
  endtask : wiggle_sdi

  task automatic set_ctrl(input logic strobe, input logic en_n);
    @(posedge i_clk) o_strobe <= strobe;
    o_out_en_n <= en_n;
  endtask : set_ctrl

  task automatic load();
    repeat (STROBE_GAP_CYC) @(posedge i_clk);
    o_strobe <= 1'b1;
    repeat (5) @(posedge i_clk);
    o_strobe <= 1'b0;
  endtask : load
endmodule : host_model

// *** testbench/test_serial_latched_driver.sv ***
// Purpose: Self-checking bench for the serial-in latched driver block.
// Assumes: host_model drives every pin except clock and reset.
// Notes:   Each scenario checks oe_n; test_load, test_hold and test_rerun_reset also check the cascade output.

`timescale 1ns/1ns

module test_serial_latched_driver;
  import driver_pkg::*;
  logic       clk;
  logic       rst_n;
  logic       shift_clk;
  logic       sdi;
  logic       strobe;
  logic       out_en_n;
  logic       sdo;
  logic [7:0] drv_out;
  logic [7:0] drv_oe_n;
  int         failures;
  int         check_count;

  initial begin
    clk = 1'b0;
    forever #(CLK_PERIOD_NS / 2) clk = ~clk;
  end

  host_model u_host (.i_clk(clk), .o_shift_clk(shift_clk), .o_sdi(sdi),
                     .o_strobe(strobe), .o_out_en_n(out_en_n));
  serial_latched_driver DUT (.i_clk(clk), .i_rst_n(rst_n), .i_shift_clk(shift_clk),
                             .i_sdi(sdi), .i_strobe(strobe), .i_out_en_n(out_en_n),
                             .o_sdo(sdo), .o_drv_out(drv_out), .o_drv_oe_n(drv_oe_n));

  // ************************************************************
  // Checks
  // ************************************************************
  task automatic settle();
    repeat (2) @(posedge clk);
    #1;
  endtask : settle

  task automatic check_oe(input logic [7:0] exp);
    check_count++;
    if (drv_oe_n !== exp || drv_out !== DRV_OUT_LEVEL) begin
      failures++;
      $display("[FAIL] %0t oe_n %h expected %h", $time, drv_oe_n, exp);
    end
  endtask : check_oe

  task automatic check_sdo(input logic exp);
    check_count++;
    if (sdo !== exp) begin
      failures++;
      $display("[FAIL] %0t sdo %b expected %b", $time, sdo, exp);
    end
  endtask : check_sdo

  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic test_load();
    u_host.shift_byte(8'ha5, 1);
    settle();
    check_sdo(1'b1);
    u_host.set_ctrl(1'b0, 1'b0);
    u_host.load();
    settle();
    check_oe(8'h5a);
  endtask : test_load

  // Slow shift clock with strobe low, then noise on the data line
  task automatic test_hold();
    u_host.shift_byte(8'h3c, 3);
    settle();
    check_oe(8'h5a);
    check_sdo(1'b0);
    u_host.wiggle_sdi(6);
    settle();
    check_sdo(1'b0);
    u_host.load();
    settle();
    check_oe(8'hc3);
  endtask : test_hold

  task automatic test_enable();
    u_host.set_ctrl(1'b0, 1'b1);
    settle();
    check_oe(DRV_OE_N_OFF);
    u_host.set_ctrl(1'b0, 1'b0);
    settle();
    check_oe(8'hc3);
  endtask : test_enable

  // Strobe and output enable held high: outputs must stay off while shifting
  task automatic test_bypass();
    u_host.set_ctrl(1'b1, 1'b1);
    u_host.shift_byte(8'h81, 1);
    settle();
    check_oe(DRV_OE_N_OFF);
    u_host.set_ctrl(1'b1, 1'b0);
    settle();
    check_oe(8'h7e);
    u_host.set_ctrl(1'b0, 1'b0);
  endtask : test_bypass

  task automatic test_rerun_reset();
    @(posedge clk) rst_n <= 1'b0;
    @(posedge clk) rst_n <= 1'b1;
    settle();
    check_oe(DRV_OE_N_OFF);
    check_sdo(1'b0);
  endtask : test_rerun_reset

  task automatic print_verdict();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : print_verdict

  // Whole run needs well under 2000 cycles
  initial begin
    #(CLK_PERIOD_NS * 20000);
    failures++;
    print_verdict();
  end

  initial begin
    failures    = 0;
    check_count = 0;
    rst_n       = 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    settle();
    check_oe(DRV_OE_N_OFF);
    test_load();
    test_hold();
    test_enable();
    test_bypass();
    test_rerun_reset();
    print_verdict();
  end
endmodule : test_serial_latched_driver
